// >>> rtl/light_sensor_pkg.sv
/*
 * Shared constants for the light sensor configuration and status control:
 * register addresses, configuration word field positions, reset values,
 * the conversion state type and the conversion timing counts.
 * Assumes a single 250 MHz clock feeding every user of these constants.
 */
// Behaviour
// - Four-bit range selector, bits 15:12, resets 1100b
// - Selector 1100b picks range, reports it in exponent
// - Conversion-time bit 11: 0 is 100 ms, 1 is 800 ms
// - Short conversion drops low result bits by range
// - Mode bits 10:9: shutdown, single, continuous
// - Single mode reads 01b, then self-clears to shutdown
// - Shutdown keeps ready and threshold flags intact
// - Overflow flag bit 8, re-evaluated every measurement
// - Manual range flags transient overload during integration
// - Auto range flags overflow only at top range
// - Auto overflow aborts, steps range up, restarts
// - Ready flag bit 7, cleared by read or active write
// - Writing shutdown mode leaves ready flag alone
// - High flag bit 6 after enough consecutive high faults
// - Low flag bit 5 after enough consecutive low faults
// - Configuration write aborts and maybe restarts conversion
// - Fault count code needs 1, 2, 4, 8 faults
package light_sensor_pkg;

  localparam logic [7:0] ADDR_RESULT = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_LOW_LIMIT = 8'h02;
  localparam logic [7:0] ADDR_HIGH_LIMIT = 8'h03;

  localparam int RANGE_MSB = 15;
  localparam int RANGE_LSB = 12;
  localparam int CONV_TIME_BIT = 11;
  localparam int MODE_MSB = 10;
  localparam int MODE_LSB = 9;
  localparam int OVERFLOW_BIT = 8;
  localparam int READY_BIT = 7;
  localparam int HIGH_FLAG_BIT = 6;
  localparam int LOW_FLAG_BIT = 5;
  localparam int MISC_MSB = 4;
  localparam int MISC_LSB = 2;
  localparam int FAULT_MSB = 1;
  localparam int FAULT_LSB = 0;
  localparam int MANT_MSB = 11;

  localparam logic [15:0] CONFIG_RESET = 16'hc810;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] LOW_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] HIGH_LIMIT_RESET = 16'hbfff;

  localparam logic [3:0] AUTO_RANGE = 4'hc;
  localparam logic [3:0] LOWEST_RANGE = 4'h0;
  localparam logic [3:0] TOP_RANGE = 4'hb;
  localparam logic [3:0] FIVE_RANGE = 4'h5;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;

  localparam logic [3:0] FAULT_SATURATE = 4'h8;

  localparam int CLK_KHZ = 250000;
  localparam int SHORT_CONV_MS = 100;
  localparam int LONG_CONV_MS = 800;
  localparam int SHORT_CONV_CYCLES = SHORT_CONV_MS * CLK_KHZ;
  localparam int LONG_CONV_CYCLES = LONG_CONV_MS * CLK_KHZ;
  localparam int TIMER_WIDTH = 28;

  typedef enum logic {
    CONV_IDLE,
    CONV_RUN
  } conv_state_t;

endpackage

// >>> rtl/fault_run_counter.sv
/*
 * Counts an uninterrupted run of threshold faults and reports when the run
 * has reached the length that the fault count code asks for.
 * Assumes eval is a one-cycle pulse per finished measurement, same clock.
 */
`timescale 1ns/1ps
module fault_run_counter
  import light_sensor_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic eval, // One pulse per finished measurement.
  input wire logic fault, // This measurement violates the limit.
  input wire logic [1:0] faultCode, // Required run length code.
  output logic reached // Pulse: run long enough at this measurement.
);

  typedef struct packed {
    logic [3:0] count;
    logic reached;
  } run_state_t;

  run_state_t s;
  run_state_t next_s;
  logic [3:0] need;
  logic [3:0] bumped;

  always_comb begin
    next_s = s;
    next_s.reached = 1'b0;
    need = 4'h1 << faultCode;
    bumped = (s.count >= FAULT_SATURATE) ? FAULT_SATURATE : s.count + 4'h1;
    if (eval) begin
      if (fault) begin
        next_s.count = bumped;
        next_s.reached = (bumped >= need);
      end else begin
        next_s.count = 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reached = s.reached;

endmodule

// >>> rtl/light_sensor_ctrl.sv
/*
 * Configuration, timing and status control of the light sensor conversion
 * engine: range handling, conversion timing, operating modes, overflow,
 * conversion-ready and threshold flags, plus the result and limit words.
 * Assumes the analog front end runs on clk, integrates while adcRun is high,
 * restarts on adcStart and presents its mantissa and overload level on clk.
 * The serial bus slave outside turns each register access into one strobe.
 */
`timescale 1ns/1ps
module light_sensor_ctrl
  import light_sensor_pkg::*;
#(
  parameter int SHORT_CYCLES = SHORT_CONV_CYCLES,
  parameter int LONG_CYCLES = LONG_CONV_CYCLES
) (
  input wire logic clk, // System clock, 250 MHz.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic regWr, // One-cycle register write strobe.
  input wire logic regRd, // One-cycle register read strobe.
  input wire logic [7:0] regAddr, // Register address.
  input wire logic [15:0] regWdata, // Write data.
  input wire logic [11:0] adcMantissa, // Converter mantissa at conversion end.
  input wire logic adcOverload, // Converter overload level.
  output logic [15:0] regRdata, // Read data, valid with regRdValid.
  output logic regRdValid, // Pulse one cycle after regRd.
  output logic adcStart, // Pulse: restart integration.
  output logic adcRun, // High while a conversion is running.
  output logic [3:0] adcRange, // Full-scale range in use.
  output logic adcLong // Long conversion time selected.
);

  typedef struct packed {
    conv_state_t fsm;
    logic running;
    logic [3:0] cfgRange;
    logic cfgLong;
    logic [1:0] cfgMode;
    logic [2:0] cfgMisc;
    logic [1:0] cfgFault;
    logic ovf;
    logic conv_ready_flag;
    logic fh;
    logic fl;
    logic [15:0] lowLimit;
    logic [15:0] highLimit;
    logic [15:0] result;
    // Sized for the long conversion at the full clock rate.
    logic [TIMER_WIDTH-1:0] timer;
    logic [3:0] curRange;
    logic overSeen;
    logic [15:0] rdata;
    logic rdValid;
    logic startPulse;
    logic evalPulse;
    logic faultHigh;
    logic faultLow;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;
  logic [1:0] faultVec;
  logic [1:0] reachedVec;

  // Limits and results are compared on a common linear scale.
  function automatic logic [26:0] toLinear(input logic [15:0] word);
    logic [26:0] lin;
    lin = {15'h0000, word[MANT_MSB:0]};
    toLinear = lin << word[RANGE_MSB:RANGE_LSB];
  endfunction

  // Short integration cannot resolve the lowest bits on the low ranges.
  function automatic logic [11:0] resolutionMask(input logic [3:0] range,
                                                 input logic longConv);
    logic [11:0] m;
    logic [1:0] drop;
    m = 12'hfff;
    drop = 2'h0;
    if (!longConv) begin
      if (range == FIVE_RANGE) begin
        drop = 2'h1;
      end else if (range == LOWEST_RANGE) begin
        drop = 2'h3;
      end else if (range < FIVE_RANGE) begin
        drop = 2'h2;
      end
    end
    resolutionMask = m << drop;
  endfunction

  // Selector codes above the automatic code are reserved; should a host write
  // one anyway, it runs as an out-of-table manual range and harms nothing.
  function automatic logic [3:0] startRange(input logic [3:0] selector);
    startRange = (selector == AUTO_RANGE) ? LOWEST_RANGE : selector;
  endfunction

  // Mode codes 10b and 11b both mean continuous conversion, so only the
  // shutdown and single-shot codes are ever decoded.
  function automatic logic isStop(input logic [1:0] mode);
    isStop = (mode == MODE_SHUTDOWN);
  endfunction

  function automatic logic isSingle(input logic [1:0] mode);
    isSingle = (mode == MODE_SINGLE);
  endfunction

  function automatic logic regHit(input logic strobe, input logic [7:0] addr,
                                  input logic [7:0] target);
    regHit = strobe && (addr == target);
  endfunction

  assign faultVec = {s.faultHigh, s.faultLow};

  // One run counter per limit: index 1 watches the high limit, index 0 the low.
  generate
    for (genvar k = 0; k < 2; k++) begin : gen_fault
      fault_run_counter u_run (
        .clk(clk),
        .nrst(nrst),
        .eval(s.evalPulse),
        .fault(faultVec[k]),
        .faultCode(s.cfgFault),
        .reached(reachedVec[k])
      );
    end
  endgenerate

  logic isAuto;
  logic overNow;
  logic atEnd;
  logic finishNow;
  logic cfgWrite;
  logic cfgRead;
  logic [1:0] newMode;
  logic [3:0] newRange;
  logic [11:0] mant;
  logic [3:0] expo;
  logic [15:0] newResult;
  // Configuration word as the host sees it, most significant field first:
  // range selector, conversion time, mode, overflow, ready, high flag, low
  // flag, three stored-only bits and the fault count code. The four flag
  // bits ignore write data; only the conversion logic sets them.
  logic [15:0] cfgWord;
  // Limits and the result on the common linear scale, worked out once.
  logic [26:0] resultLin;
  logic [26:0] highLin;
  logic [26:0] lowLin;

  always_comb begin
    next_s = s;
    next_s.startPulse = 1'b0;
    next_s.evalPulse = 1'b0;
    next_s.rdValid = 1'b0;
    isAuto = (s.cfgRange == AUTO_RANGE);
    overNow = s.overSeen | adcOverload;
    atEnd = s.cfgLong ? (s.timer == TIMER_WIDTH'(LONG_CYCLES - 1))
                      : (s.timer == TIMER_WIDTH'(SHORT_CYCLES - 1));
    finishNow = 1'b0;
    cfgWrite = regHit(regWr, regAddr, ADDR_CONFIG);
    cfgRead = regHit(regRd, regAddr, ADDR_CONFIG);
    newMode = regWdata[MODE_MSB:MODE_LSB];
    newRange = regWdata[RANGE_MSB:RANGE_LSB];
    mant = adcMantissa & resolutionMask(s.curRange, s.cfgLong);
    // The exponent always reports the range that the conversion really used.
    expo = s.curRange;
    newResult = {expo, mant};
    cfgWord = {s.cfgRange, s.cfgLong, s.cfgMode, s.ovf, s.conv_ready_flag, s.fh, s.fl,
               s.cfgMisc, s.cfgFault};
    resultLin = toLinear(newResult);
    highLin = toLinear(s.highLimit);
    lowLin = toLinear(s.lowLimit);

    // Reads return the word as it stood before any clear takes effect.
    if (regRd) begin
      next_s.rdValid = 1'b1;
      case (regAddr)
        ADDR_RESULT: next_s.rdata = s.result;
        ADDR_CONFIG: next_s.rdata = cfgWord;
        ADDR_LOW_LIMIT: next_s.rdata = s.lowLimit;
        ADDR_HIGH_LIMIT: next_s.rdata = s.highLimit;
        default: next_s.rdata = 16'h0000;
      endcase
    end
    if (cfgRead) begin
      next_s.fh = 1'b0;
      next_s.fl = 1'b0;
    end
    if (regHit(regWr, regAddr, ADDR_LOW_LIMIT)) begin
      next_s.lowLimit = regWdata;
    end
    if (regHit(regWr, regAddr, ADDR_HIGH_LIMIT)) begin
      next_s.highLimit = regWdata;
    end

    case (s.fsm)
      CONV_IDLE: begin
        // Shutdown holds every status flag as it stands, so the host can
        // still read what the last conversion reported.
        next_s.running = 1'b0;
      end
      CONV_RUN: begin
        next_s.timer = s.timer + 1'b1;
        // A manual range keeps a brief overload until the end, because the
        // integrator cannot win back the charge that it lost.
        next_s.overSeen = overNow;
        if (isAuto && adcOverload && (s.curRange < TOP_RANGE)) begin
          // Each step restarts the integration from zero one range higher.
          next_s.curRange = s.curRange + 4'h1;
          next_s.timer = '0;
          next_s.overSeen = 1'b0;
          next_s.startPulse = 1'b1;
        end else if (atEnd) begin
          finishNow = 1'b1;
          // In auto mode overload can only survive to here on the top range.
          next_s.ovf = overNow;
          next_s.result = newResult;
          next_s.evalPulse = 1'b1;
          // Strict compares: a result equal to a limit is no fault.
          next_s.faultHigh = resultLin > highLin;
          next_s.faultLow = resultLin < lowLin;
          if (isSingle(s.cfgMode)) begin
            next_s.cfgMode = MODE_SHUTDOWN;
            next_s.fsm = CONV_IDLE;
            next_s.running = 1'b0;
          end else begin
            next_s.timer = '0;
            next_s.overSeen = 1'b0;
            // Continuous mode starts over at once, back on the selected range
            // or, when ranging automatically, on the lowest one.
            next_s.curRange = startRange(s.cfgRange);
            next_s.startPulse = 1'b1;
          end
        end
      end
      default: begin
        next_s.fsm = CONV_IDLE;
        next_s.running = 1'b0;
      end
    endcase

    // A configuration write overrides the conversion's state, timer and range; a conversion ending this cycle still stores its result.
    if (cfgWrite) begin
      next_s.cfgRange = newRange;
      next_s.cfgLong = regWdata[CONV_TIME_BIT];
      next_s.cfgMode = newMode;
      // Latch, polarity and exponent-mask bits are only stored and read back.
      next_s.cfgMisc = regWdata[MISC_MSB:MISC_LSB];
      next_s.cfgFault = regWdata[FAULT_MSB:FAULT_LSB];
      next_s.timer = '0;
      next_s.overSeen = 1'b0;
      next_s.curRange = startRange(newRange);
      if (isStop(newMode)) begin
        next_s.fsm = CONV_IDLE;
        next_s.running = 1'b0;
        next_s.startPulse = 1'b0;
      end else begin
        next_s.fsm = CONV_RUN;
        next_s.running = 1'b1;
        next_s.startPulse = 1'b1;
      end
    end

    // The ready flag: set at each conversion end wins over any clear.
    if (finishNow) begin
      next_s.conv_ready_flag = 1'b1;
    end else if (cfgRead || (cfgWrite && !isStop(newMode))) begin
      next_s.conv_ready_flag = 1'b0;
    end
    // A run that reached its length sets its flag; that set wins over a
    // configuration read clearing the flag in the same cycle.
    if (reachedVec[1]) begin
      next_s.fh = 1'b1;
    end
    if (reachedVec[0]) begin
      next_s.fl = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      // Clear everything, then load the state, configuration, limit and result fields from their reset values.
      s <= '0;
      s.fsm <= CONV_IDLE;
      s.cfgRange <= CONFIG_RESET[RANGE_MSB:RANGE_LSB];
      s.cfgLong <= CONFIG_RESET[CONV_TIME_BIT];
      s.cfgMode <= CONFIG_RESET[MODE_MSB:MODE_LSB];
      s.cfgMisc <= CONFIG_RESET[MISC_MSB:MISC_LSB];
      s.cfgFault <= CONFIG_RESET[FAULT_MSB:FAULT_LSB];
      s.lowLimit <= LOW_LIMIT_RESET;
      s.highLimit <= HIGH_LIMIT_RESET;
      s.result <= RESULT_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a register field, so nothing combinational reaches a pin.
  assign regRdata = s.rdata;
  assign regRdValid = s.rdValid;
  assign adcStart = s.startPulse;
  assign adcRun = s.running;
  assign adcRange = s.curRange;
  assign adcLong = s.cfgLong;

endmodule

// >>> bench/light_sensor_properties.sv
/*
 * Port checker for light_sensor_ctrl, bound to every instance of it.
 * Assumes one clock and the synchronous active-low reset nrst.
 */
`timescale 1ns/1ps
module light_sensor_checker
  import light_sensor_pkg::*;
#(
  parameter int SHORT_CYCLES = 20,
  parameter int LONG_CYCLES = 40
) (
  input wire logic clk, // Clock.
  input wire logic nrst, // Reset.
  input wire logic regWr, // Write strobe.
  input wire logic regRd, // Read strobe.
  input wire logic [7:0] regAddr, // Address.
  input wire logic [15:0] regWdata, // Write data.
  input wire logic [11:0] adcMantissa, // Mantissa.
  input wire logic adcOverload, // Overload.
  input wire logic [15:0] regRdata, // Read data.
  input wire logic regRdValid, // Read answer.
  input wire logic adcStart, // Restart pulse.
  input wire logic adcRun, // Running.
  input wire logic [3:0] adcRange, // Range in use.
  input wire logic adcLong // Long time.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic cfgWr;
  logic rdCfg;
  logic autoMode;
  int runCnt;
  assign cfgWr = regWr && regAddr == ADDR_CONFIG;
  assign rdCfg = regRd && regAddr == ADDR_CONFIG;
  // Tracks the host's range choice, since only the port view is available here.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      autoMode <= 1'b1;
      runCnt <= 0;
    end else begin
      if (cfgWr) begin
        autoMode <= regWdata[15:12] == AUTO_RANGE;
      end
      runCnt <= adcStart ? 1 : (adcRun ? runCnt + 1 : 0);
    end
  end
  property p_start;
    cfgWr && regWdata[10:9] != MODE_SHUTDOWN |=> adcStart && adcRun;
  endproperty
  a_start: assert property (p_start) else $error("write did not start");
  property p_range;
    cfgWr && regWdata[10:9] != MODE_SHUTDOWN |=> adcRange ==
      ($past(regWdata[15:12]) == AUTO_RANGE ? LOWEST_RANGE : $past(regWdata[15:12]));
  endproperty
  a_range: assert property (p_range) else $error("wrong start range");
  property p_long;
    cfgWr |=> adcLong == $past(regWdata[11]);
  endproperty
  a_long: assert property (p_long) else $error("wrong time select");
  property p_stop;
    cfgWr && regWdata[10:9] == MODE_SHUTDOWN |=> !adcRun;
  endproperty
  a_stop: assert property (p_stop) else $error("shutdown kept running");
  // No conversion can finish within three cycles of an idle read.
  property p_ready;
    (rdCfg && !adcRun) ##[1:3] rdCfg |=> !regRdata[READY_BIT];
  endproperty
  a_ready: assert property (p_ready) else $error("ready not cleared");
  property p_chg;
    adcRun && $changed(adcRange) |-> adcStart;
  endproperty
  a_chg: assert property (p_chg) else $error("range moved mid conversion");
  property p_step;
    autoMode && adcRun && adcOverload && !regWr && adcRange < TOP_RANGE
      |=> adcStart && adcRange == $past(adcRange) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("no range step");
  property p_len;
    adcRun && !adcStart |-> runCnt < (adcLong ? LONG_CYCLES : SHORT_CYCLES);
  endproperty
  a_len: assert property (p_len) else $error("conversion too long");
  c_single: cover property ($fell(adcRun));
  c_top: cover property (adcStart && adcRange == TOP_RANGE);
  c_ready: cover property (rdCfg ##1 regRdValid && regRdata[READY_BIT]);
endmodule
bind light_sensor_ctrl light_sensor_checker #(.SHORT_CYCLES(SHORT_CYCLES),
  .LONG_CYCLES(LONG_CYCLES)) light_sensor_checker_inst (.clk(clk), .nrst(nrst),
  .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
  .adcMantissa(adcMantissa), .adcOverload(adcOverload), .regRdata(regRdata),
  .regRdValid(regRdValid), .adcStart(adcStart), .adcRun(adcRun),
  .adcRange(adcRange), .adcLong(adcLong));

// >>> bench/host_model.sv
/*
 * Host controller model: one-strobe register writes and reads.
 * Assumes the serial bus slave is folded into single-cycle strobes.
 */
`timescale 1ns/1ps
module host_model (
  input wire logic clk, // Clock.
  output logic regWr, // Write strobe.
  output logic regRd, // Read strobe.
  output logic [7:0] regAddr, // Address.
  output logic [15:0] regWdata, // Write data.
  input wire logic regRdValid, // Read answer.
  input wire logic [15:0] regRdata // Read data.
);
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 16'h0000;
  end
  // Callers keep the range field at 1100b or below.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    regWr = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWr = 1'b0;
    // Stale data is inverted so a late sample cannot pass by luck.
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    regRd = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRd = 1'b0;
    // The answer stands only in the cycle after the strobe edge.
    d = regRdValid ? regRdata : 16'hxxxx;
  endtask
endmodule

// >>> bench/tb.sv
/*
 * Self-checking bench for light_sensor_ctrl with short conversion counts.
 * Assumes host_model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin nFail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  import light_sensor_pkg::*;
  localparam int SC = 20;
  localparam int LC = 40;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic regWr, regRd, regRdValid, adcStart, adcRun, adcLong;
  logic [7:0] regAddr;
  logic [15:0] regWdata, regRdata, d;
  logic [11:0] adcMantissa = 12'h000;
  logic adcOverload = 1'b0;
  logic [3:0] adcRange;
  logic [3:0] ovLimit = 4'h0;
  int nFail = 0;
  int nChecks = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  // Front end: overloads while the range in use is below ovLimit.
  always @(negedge clk) adcOverload <= adcRun && adcRange < ovLimit;
  light_sensor_ctrl #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC)) light_sensor_ctrl_inst (
    .clk(clk), .nrst(nrst), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWdata(regWdata), .adcMantissa(adcMantissa), .adcOverload(adcOverload),
    .regRdata(regRdata), .regRdValid(regRdValid), .adcStart(adcStart),
    .adcRun(adcRun), .adcRange(adcRange), .adcLong(adcLong));
  host_model host_model_inst (.clk(clk), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdValid(regRdValid), .regRdata(regRdata));
  task close_out;
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      nFail++;
      close_out();
    end
  end
  // Flags land two cycles after the result, hence the short settle.
  task wait_idle;
    int i;
    i = 0;
    @(negedge clk);
    while (adcRun && i < 200) begin
      @(negedge clk);
      i++;
    end
    repeat (4) @(negedge clk);
  endtask
  task t_reset;
    host_model_inst.rd(ADDR_CONFIG, d);
    `CHK("config", CONFIG_RESET, d)
    `CHK("long", 1'b1, adcLong)
  endtask
  task t_single;
    host_model_inst.wr(ADDR_HIGH_LIMIT, 16'h0001);
    adcMantissa = 12'hfff;
    host_model_inst.wr(ADDR_CONFIG, 16'h3210);
    wait_idle();
    host_model_inst.rd(ADDR_RESULT, d);
    `CHK("result", 16'h3ffc, d)
    host_model_inst.wr(ADDR_CONFIG, 16'h3010);
    host_model_inst.rd(ADDR_CONFIG, d);
    `CHK("config", 16'h30d0, d)
    host_model_inst.rd(ADDR_CONFIG, d);
    `CHK("config", 16'h3010, d)
  endtask
  task t_fault;
    host_model_inst.wr(ADDR_LOW_LIMIT, 16'h0002);
    adcMantissa = 12'h001;
    for (int k = 0; k < 2; k++) begin
      host_model_inst.wr(ADDR_CONFIG, 16'h0a11);
      repeat (5) @(posedge clk);
      ovLimit = (k == 0) ? 4'h1 : 4'h0;
      @(posedge clk);
      ovLimit = 4'h0;
      wait_idle();
      host_model_inst.rd(ADDR_CONFIG, d);
      `CHK("config", (k == 0) ? 16'h0991 : 16'h08b1, d)
    end
  endtask
  task t_auto;
    adcMantissa = 12'h0ff;
    ovLimit = 4'h2;
    host_model_inst.wr(ADDR_CONFIG, 16'hc210);
    wait_idle();
    host_model_inst.rd(ADDR_RESULT, d);
    `CHK("result", 16'h20fc, d)
    host_model_inst.rd(ADDR_CONFIG, d);
    `CHK("overflow", 1'b0, d[OVERFLOW_BIT])
    ovLimit = 4'hf;
    adcMantissa = 12'hfff;
    host_model_inst.wr(ADDR_CONFIG, 16'hc210);
    wait_idle();
    ovLimit = 4'h0;
    host_model_inst.rd(ADDR_RESULT, d);
    `CHK("result", 16'hbfff, d)
    host_model_inst.rd(ADDR_CONFIG, d);
    `CHK("overflow", 1'b1, d[OVERFLOW_BIT])
  endtask
  task t_cont;
    int n;
    n = 0;
    host_model_inst.wr(ADDR_CONFIG, 16'h4410);
    repeat (8) @(negedge clk);
    host_model_inst.wr(ADDR_CONFIG, 16'h5410);
    // The write task returns inside the one cycle in which the start pulse stands.
    `CHK("start", 1'b1, adcStart)
    `CHK("range", 4'h5, adcRange)
    `CHK("long", 1'b0, adcLong)
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!adcStart && n < 100);
    `CHK("period", SC, n)
    `CHK("run", 1'b1, adcRun)
    host_model_inst.rd(ADDR_RESULT, d);
    `CHK("result", 16'h5ffe, d)
    host_model_inst.wr(ADDR_CONFIG, 16'h5010);
    @(negedge clk);
    `CHK("run", 1'b0, adcRun)
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_single();
    t_fault();
    t_auto();
    t_cont();
    close_out();
  end
endmodule
